// ===== rtl/cpf_top.sv
/*
 Capture pin edge selection, capture flags and entry interrupt flags,
 reached over APB. Assumes the entry engine reports each met, enabled entry
 interrupt as a one-cycle pulse with its entry number.
*/
`timescale 1ns/1ps
`default_nettype none
module cpf_top #(
   parameter int ENTRY_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cpf_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic entry_irq_valid,
   input wire logic [ENTRY_W-1:0] entry_irq_num,
   input wire logic [cpf_pkg::PIN_COUNT-1:0] capture_pin,
   output logic [cpf_pkg::PIN_COUNT-1:0] capture_trigger,
   output logic irq
);
   import cpf_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   logic [PIN_COUNT-1:0] fall_r, rise_r, ena_r, cflag_r;
   logic [ENTRY_FLAGS-1:0] eflag_r;
   logic [STATUS_W-1:0] irq_en_r;
   logic [PRESCALE_W-1:0] prescale_r;
   logic [PIN_COUNT-1:0] cap_event;
   logic [ENTRY_FLAGS-1:0] entry_set;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r, irq_r;
   logic [PIN_COUNT-1:0] capture_trigger_r;
   logic wr_en, rd_take, mapped;
   logic [STATUS_W-1:0] status;

   // ****************************************************************
   // Edge detectors
   // ****************************************************************
   cpf_cap_if cap_bus [PIN_COUNT] ();
   for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
      assign cap_bus[g].pin = capture_pin[g];
      assign cap_bus[g].capture_on_rise = rise_r[g];
      assign cap_bus[g].capture_on_fall = fall_r[g];
      assign cap_bus[g].capture_prescale_select = prescale_r;
      assign cap_event[g] = cap_bus[g].edge_event;
      cpf_edge #(
         .USE_PRESCALE(g >= PRESCALED_FIRST_PIN)
      ) u_edge (
         .pclk(pclk),
         .presetn(presetn),
         .cap(cap_bus[g])
      );
   end

   // Entry numbers count from the start address downward, so the flag is
   // simply the low three bits of the number supplied by the engine.
   always_comb begin
      entry_set = '0;
      if (entry_irq_valid) begin
         entry_set[entry_irq_num[2:0]] = 1'b1; // RULE_01 RULE_02 RULE_03 RULE_05
      end
   end

   // ****************************************************************
   // Register access helpers
   // ****************************************************************
   function automatic logic [7:0] pack_pair(input int lo);
      pack_pair = {ena_r[lo+1], cflag_r[lo+1], rise_r[lo+1], fall_r[lo+1],
                   ena_r[lo], cflag_r[lo], rise_r[lo], fall_r[lo]}; // RULE_07
   endfunction : pack_pair

   function automatic logic hit(input logic [ADDR_W-1:0] idx);
      hit = (paddr == byte_addr(idx));
   endfunction : hit

   assign wr_en = psel & penable & pready_r & pwrite;
   assign rd_take = psel & penable & ~pready_r;
   assign mapped = hit(IDX_ENTRY_FLAGS) || hit(IDX_CTRL_12) || hit(IDX_CTRL_34) ||
                   hit(IDX_PRESCALE) || hit(IDX_IRQ_STATUS) || hit(IDX_IRQ_CLEAR) ||
                   hit(IDX_IRQ_ENABLE);
   assign status = {cflag_r, eflag_r};

   // ****************************************************************
   // APB slave, one wait state
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= rd_take;
         pslverr_r <= rd_take & ~mapped;
         if (rd_take) begin
            // Writes answer zero too, so an error answer never shows stale data.
            if (pwrite) begin
               prdata_r <= '0;
            end else if (hit(IDX_ENTRY_FLAGS)) begin
               prdata_r <= {24'h000000, eflag_r}; // RULE_15
            end else if (hit(IDX_CTRL_12)) begin
               prdata_r <= {24'h000000, pack_pair(0)}; // RULE_13
            end else if (hit(IDX_CTRL_34)) begin
               prdata_r <= {24'h000000, pack_pair(2)}; // RULE_14
            end else if (hit(IDX_PRESCALE)) begin
               prdata_r <= {26'h0000000, prescale_r, 3'h0};
            end else if (hit(IDX_IRQ_STATUS)) begin
               prdata_r <= {20'h00000, status};
            end else if (hit(IDX_IRQ_ENABLE)) begin
               prdata_r <= {20'h00000, irq_en_r};
            end else begin
               prdata_r <= '0;
            end
         end
      end
   end

   // ****************************************************************
   // Control bits
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fall_r <= RESET_NIBBLE; // RULE_11
         rise_r <= RESET_NIBBLE;
         ena_r <= RESET_NIBBLE;
         prescale_r <= RESET_PRESCALE;
         irq_en_r <= RESET_IRQ_ENABLE;
      end else if (wr_en) begin
         if (hit(IDX_CTRL_12) || hit(IDX_CTRL_34)) begin
            for (int k = 0; k < 2; k++) begin
               automatic int p = (hit(IDX_CTRL_34) ? 2 : 0) + k;
               fall_r[p] <= pwdata[k*NIBBLE_W+FLD_FALL]; // RULE_12
               rise_r[p] <= pwdata[k*NIBBLE_W+FLD_RISE];
               ena_r[p] <= pwdata[k*NIBBLE_W+FLD_ENA];
            end
         end else if (hit(IDX_PRESCALE)) begin
            prescale_r <= pwdata[PRESCALE_LSB +: PRESCALE_W];
         end else if (hit(IDX_IRQ_ENABLE)) begin
            irq_en_r <= pwdata[STATUS_W-1:0];
         end
      end
   end

   // ****************************************************************
   // Flags: a new event wins over a clear in the same cycle
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cflag_r <= RESET_NIBBLE; // RULE_11
      end else begin
         for (int p = 0; p < PIN_COUNT; p++) begin
            automatic logic clr = 1'b0;
            if (wr_en && hit(p < 2 ? IDX_CTRL_12 : IDX_CTRL_34)) begin
               clr = ~pwdata[(p % 2)*NIBBLE_W+FLD_FLAG]; // RULE_17 RULE_10
            end
            if (wr_en && hit(IDX_IRQ_CLEAR) && pwdata[STATUS_CAP_LSB+p]) begin
               clr = 1'b1;
            end
            if (cap_event[p]) begin
               cflag_r[p] <= 1'b1; // RULE_08 RULE_17
            end else if (clr) begin
               cflag_r[p] <= 1'b0; // RULE_12
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eflag_r <= RESET_BYTE; // RULE_11
      end else begin
         for (int b = 0; b < ENTRY_FLAGS; b++) begin
            if (entry_set[b]) begin
               eflag_r[b] <= 1'b1; // RULE_01 RULE_17
            end else if (wr_en && hit(IDX_ENTRY_FLAGS) && !pwdata[b]) begin
               eflag_r[b] <= 1'b0; // RULE_04 RULE_17
            end else if (wr_en && hit(IDX_IRQ_CLEAR) && pwdata[b]) begin
               eflag_r[b] <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_trigger_r <= RESET_NIBBLE;
         irq_r <= 1'b0;
      end else begin
         capture_trigger_r <= cap_event; // RULE_08
         // The extra enable register defaults open so entry flags alone, and capture flags with their ena_r bit set, raise irq.
         irq_r <= |(eflag_r & irq_en_r[ENTRY_FLAGS-1:0]) |
                  |(cflag_r & ena_r & irq_en_r[STATUS_W-1:STATUS_CAP_LSB]); // RULE_09 RULE_18
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign capture_trigger = capture_trigger_r;
   assign irq = irq_r;
endmodule : cpf_top
`default_nettype wire

// ===== rtl/cpf_pkg.sv
/*
 Constants for the capture pin edge and entry interrupt flag block: register
 indices, byte addresses, field positions and reset values.
 Assumes a single 250 MHz clock and APB access with 32-bit data.
*/
// Operation
// RULE_01: Enabled entry interrupt condition sets entry flag.
// RULE_02: Flag bit is entry number modulo eight.
// RULE_03: Entry zero is highest address, evaluated first.
// RULE_04: Software clears entry flag in service routine.
// RULE_05: Entry flags ignore the area interrupt enable.
// RULE_06: Rise and fall selects pick capture edges.
// RULE_07: Two pins per control register, four bits each.
// RULE_08: Selected edge triggers capture and sets flag.
// RULE_09: Capture interrupt raised only when enabled.
// RULE_10: Software clears capture flag in its routine.
// RULE_11: All flag and control bits reset to zero; irq_en_r resets to all ones (RESET_IRQ_ENABLE = 12'hFFF).
// RULE_12: Flags readable, clearable, never set by software.
// RULE_13: Pins one and two control at 104Ah.
// RULE_14: Pins three and four control at 104Bh.
// RULE_15: Entry flag register decoded at 1049h.
// RULE_16: Prescaler divide one to eight, pins three onward.
// RULE_17: Write zero clears flag; set beats clear.
// RULE_18: Interrupt on enabled capture flag or entry flag.
`default_nettype none
package cpf_pkg;
   localparam int ADDR_W = 16;
   localparam int PIN_COUNT = 4;
   localparam int ENTRY_FLAGS = 8;
   localparam int PRESCALE_W = 3;
   // Printed offsets are not word aligned, so they are register indices.
   localparam logic [ADDR_W-1:0] IDX_ENTRY_FLAGS = 16'h1049;
   localparam logic [ADDR_W-1:0] IDX_CTRL_12 = 16'h104A;
   localparam logic [ADDR_W-1:0] IDX_CTRL_34 = 16'h104B;
   localparam logic [ADDR_W-1:0] IDX_PRESCALE = 16'h104D;
   localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 16'h1050;
   localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR = 16'h1051;
   localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 16'h1052;
   // Field positions within one pin nibble.
   localparam int FLD_FALL = 0;
   localparam int FLD_RISE = 1;
   localparam int FLD_FLAG = 2;
   localparam int FLD_ENA = 3;
   localparam int NIBBLE_W = 4;
   localparam int PRESCALE_LSB = 3;
   localparam int STATUS_CAP_LSB = 8;
   localparam int STATUS_W = 12;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [3:0] RESET_NIBBLE = 4'h0;
   localparam logic [STATUS_W-1:0] RESET_IRQ_ENABLE = 12'hFFF;
   localparam logic [PRESCALE_W-1:0] RESET_PRESCALE = 3'h0;
   localparam int PRESCALED_FIRST_PIN = 2;
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] idx);
      byte_addr = {idx[ADDR_W-3:0], 2'b00};
   endfunction : byte_addr
endpackage : cpf_pkg
`default_nettype wire

// ===== rtl/cpf_cap_if.sv
/*
 Interface between the top and one capture edge detector.
 Assumes the pin level is synchronous to the block clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface cpf_cap_if;
   import cpf_pkg::*;
   logic pin;
   logic capture_on_rise;
   logic capture_on_fall;
   logic [PRESCALE_W-1:0] capture_prescale_select;
   logic edge_event;
   modport ctrl (output pin, output capture_on_rise, output capture_on_fall,
                 output capture_prescale_select, input edge_event);
   modport det (input pin, input capture_on_rise, input capture_on_fall,
                input capture_prescale_select, output edge_event);
endinterface : cpf_cap_if
`default_nettype wire

// ===== rtl/cpf_edge.sv
/*
 Edge detector with optional prescaler for one capture pin.
 Assumes pin input is already synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module cpf_edge #(
   parameter bit USE_PRESCALE = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   cpf_cap_if.det cap
);
   import cpf_pkg::*;
   logic pin_prev_r;
   logic [PRESCALE_W-1:0] div_cnt_r;
   logic sel_edge;
   logic last_of_group;

   // Edge choice per the two select bits; both low disables capture.
   assign sel_edge = (cap.capture_on_rise & cap.pin & ~pin_prev_r) |
                     (cap.capture_on_fall & ~cap.pin & pin_prev_r); // RULE_06
   // A select lowered mid-count ends the group at once, never stranding it.
   assign last_of_group = !USE_PRESCALE || (div_cnt_r >= cap.capture_prescale_select);
   assign cap.edge_event = sel_edge & last_of_group; // RULE_16

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev_r <= 1'b0;
      end else begin
         pin_prev_r <= cap.pin;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_r <= RESET_PRESCALE;
      end else if (sel_edge) begin
         div_cnt_r <= last_of_group ? RESET_PRESCALE : div_cnt_r + 3'h1; // RULE_16
      end
   end
endmodule : cpf_edge
`default_nettype wire

// ===== tb/cpf_props.sv
/*
 Checker for cpf_top: APB answer timing, trigger causes and interrupt causes.
 Assumes it is bound to cpf_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module cpf_props #(
   parameter int ENTRY_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cpf_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic entry_irq_valid,
   input wire logic [ENTRY_W-1:0] entry_irq_num,
   input wire logic [cpf_pkg::PIN_COUNT-1:0] capture_pin,
   input wire logic [cpf_pkg::PIN_COUNT-1:0] capture_trigger,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   pready_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   wait_state_a: assert property (psel && penable && !$past(penable) |=> pready)
      else $error("pready not one cycle after access start");
   err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer without pready or with data");
   reset_quiet_a: assert property ($rose(presetn) |-> !irq && capture_trigger == 4'h0)
      else $error("outputs active right after reset");
   entry_irq_a: assert property (entry_irq_valid |-> ##2 irq)
      else $error("entry event gave no interrupt");
   // A prescaled trigger still needs a pin change one or two samples earlier.
   trig_cause_a: assert property (!(|(capture_trigger & ~(($past(capture_pin) ^
      $past(capture_pin, 2)) | ($past(capture_pin, 2) ^ $past(capture_pin, 3))))))
      else $error("trigger without a pin change");
   irq_rise_a: assert property ($rose(irq) |-> $past(entry_irq_valid, 2) ||
      $past(|capture_trigger) || $past(pready && pwrite) || $past(pready && pwrite, 2))
      else $error("interrupt rose without a cause");
   irq_fall_a: assert property ($fell(irq) |-> $past(pready && pwrite) ||
      $past(pready && pwrite, 2) || $past(pready && pwrite, 3))
      else $error("interrupt fell without a software write");
   cover property (entry_irq_valid ##2 irq);
   cover property (|capture_trigger);
   cover property (pslverr);
endmodule : cpf_props
bind cpf_top cpf_props #(.ENTRY_W(ENTRY_W)) i_cpf_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .entry_irq_valid(entry_irq_valid),
   .entry_irq_num(entry_irq_num), .capture_pin(capture_pin),
   .capture_trigger(capture_trigger), .irq(irq));
`default_nettype wire

// ===== tb/cpf_pins.sv
/*
 Model of the digital sources on the capture pins.
 Assumes the bench names each pin level; slow adds a cycle of lag.
*/
`timescale 1ns/1ps
`default_nettype none
module cpf_pins (
   input wire logic pclk,
   input wire logic slow,
   input wire logic [3:0] level_cmd,
   output logic [3:0] capture_pin
);
   logic [3:0] lag_r;
   // Sources are synchronous to pclk, so no metastability stage is modelled.
   always_ff @(posedge pclk) begin
      lag_r <= level_cmd;
      capture_pin <= slow ? lag_r : level_cmd;
   end
endmodule : cpf_pins
`default_nettype wire

// ===== tb/cpf_top_tb.sv
/*
 Self-checking bench for cpf_top: registers, entry flags, capture edges, irq.
 Assumes cpf_pkg and cpf_pins; reads are checked by a watching process.
*/
`timescale 1ns/1ps
`default_nettype none
module cpf_top_tb;
   import cpf_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, entry_irq_valid, slow, pready, pslverr, irq;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [7:0] entry_irq_num;
   logic [3:0] level_cmd, capture_pin, capture_trigger;
   logic [32:0] exp_q[$];
   int err_count, n_checks, base;
   int trig_cnt[4];
   cpf_top i_cpf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .entry_irq_valid(entry_irq_valid), .entry_irq_num(entry_irq_num),
      .capture_pin(capture_pin), .capture_trigger(capture_trigger), .irq(irq));
   cpf_pins i_cpf_pins (.pclk(pclk), .slow(slow), .level_cmd(level_cmd),
      .capture_pin(capture_pin));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction : xs
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // A read notes {pslverr, prdata} expected; a write sends v[31:0].
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [32:0] v);
      int n;
      if (!wr) exp_q.push_back(v);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx[13:0], 2'b00};
      pwdata <= v[31:0];
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_count++;
         end_of_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic ent(input logic [2:0] k);
      seed = xs(seed);
      entry_irq_valid <= 1'b1;
      entry_irq_num <= {seed[7:3], k};
      @(posedge pclk);
      entry_irq_valid <= 1'b0;
      @(posedge pclk);
   endtask : ent
   task automatic pin(input int p, input logic v);
      level_cmd[p] <= v;
      repeat (6) @(posedge pclk);
   endtask : pin
   always @(posedge pclk) begin
      for (int i = 0; i < 4; i++) trig_cnt[i] += int'(capture_trigger[i]);
      if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
   end
   initial begin
      seed = 32'h24F8BB7F;
      {presetn, psel, penable, pwrite, entry_irq_valid, slow} = 6'h00;
      paddr = '0;
      pwdata = '0;
      entry_irq_num = '0;
      level_cmd = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, 16'h1049, 33'h0);
      apb(0, 16'h104A, 33'h0);
      apb(0, 16'h104B, 33'h0);
      apb(0, 16'h1060, 33'h1_0000_0000);
      apb(1, 16'h104A, 33'hFF);
      apb(0, 16'h104A, 33'hBB);
      apb(1, 16'h104A, 33'h0);
      $display("register test done");
      for (int k = 0; k < 8; k++) ent(k[2:0]);
      apb(0, 16'h1049, 33'hFF);
      chk({32'h0, irq}, 33'h1);
      apb(0, 16'h1050, 33'hFF);
      apb(1, 16'h1051, 33'h0F);
      apb(0, 16'h1049, 33'hF0);
      apb(1, 16'h1049, 33'h3F);
      apb(0, 16'h1049, 33'h30);
      apb(1, 16'h1052, 33'h0);
      repeat (2) @(posedge pclk);
      chk({32'h0, irq}, 33'h0);
      apb(1, 16'h1052, 33'hFFF);
      apb(1, 16'h1049, 33'h0);
      repeat (2) @(posedge pclk);
      chk({32'h0, irq}, 33'h0);
      $display("entry flag test done");
      for (int p = 0; p < 4; p++) begin
         for (int m = 0; m < 4; m++) begin
            base = trig_cnt[p];
            slow <= m[0];
            apb(1, 16'h104A + 16'(p / 2), 33'(m << 4 * (p % 2)));
            pin(p, 1'b1);
            pin(p, 1'b0);
            chk(33'(trig_cnt[p] - base), 33'(m % 2 + m / 2));
            chk({32'h0, irq}, 33'h0);
            apb(0, 16'h104A + 16'(p / 2), 33'((4 * (m != 0) + m) << 4 * (p % 2)));
            apb(1, 16'h104A + 16'(p / 2), 33'h0);
         end
      end
      apb(1, 16'h104A, 33'h0A);
      pin(0, 1'b1);
      chk({32'h0, irq}, 33'h1);
      apb(1, 16'h104A, 33'h0E);
      apb(0, 16'h104A, 33'h0E);
      apb(1, 16'h104A, 33'h0A);
      repeat (2) @(posedge pclk);
      chk({32'h0, irq}, 33'h0);
      pin(0, 1'b0);
      $display("capture test done");
      apb(1, 16'h104D, 33'h08);
      apb(1, 16'h104B, 33'h02);
      base = trig_cnt[2];
      repeat (4) begin
         pin(2, 1'b1);
         pin(2, 1'b0);
      end
      chk(33'(trig_cnt[2] - base), 33'h2);
      $display("prescale test done");
      end_of_test();
   end
endmodule : cpf_top_tb
`default_nettype wire
